// ===== shared/tcp_pkg.sv
// Constants and types shared by both ends of the transmit command link
// Overview of operation
// - Host sends command words before buffer payload
// - Each command is two consecutive 32-bit words
// - Second word carries free 16-bit packet tag
// - Tag copied into the packet status word
// - Host sends both words for every buffer
// - Host repeats identical second word per packet
// - Differing second word raises transmit error
// - Bit 31 requests loaded flag after buffer
// - Host writes zeros to bits 30:26
// - Bits 25:24 select end alignment, 00 4-byte
// - Device discards end alignment padding words
// - Device keeps only payload, drops command words
// - Bits 20:16 give first payload byte offset
// - Bit 13 opens a new packet
// - Bit 12 closes packet after this buffer
package tcp_pkg;
   localparam int DW = 32;
   localparam int TAG_W = 16;
   localparam int CNT_W = 10;
   localparam int IRQ_W = 2;
   localparam int IOC_BIT = 31;
   localparam int RSV_HI = 30;
   localparam int RSV_LO = 26;
   localparam int ALIGN_HI = 25;
   localparam int ALIGN_LO = 24;
   localparam int OFF_HI = 20;
   localparam int OFF_LO = 16;
   localparam int FIRST_BIT = 13;
   localparam int LAST_BIT = 12;
   localparam int SIZE_HI = 10;
   localparam int SIZE_LO = 0;
   localparam int TAG_HI = 31;
   localparam int TAG_LO = 16;
   localparam logic [1:0] ALIGN_4 = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [1:0] ALIGN_RSV = 2'h3;
   localparam logic [CNT_W-1:0] MASK_4 = 10'h000;
   localparam logic [CNT_W-1:0] MASK_16 = 10'h003;
   localparam logic [CNT_W-1:0] MASK_32 = 10'h007;
   localparam logic [3:0] BE_ALL = 4'hF;
   localparam logic [7:0] REG_DATA = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam int STAT_ERR_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_BODY} tcp_state_t;
endpackage : tcp_pkg

// ===== shared/tcp_link_if.sv
// Word link from host controller into the command parser
`timescale 1ns/1ps
`default_nettype none
interface tcp_link_if;
   logic wr;
   logic [tcp_pkg::DW-1:0] data;
   logic transmit_error_flag;
   logic transmit_buffer_loaded_flag;
   modport host (output wr, output data, input transmit_error_flag, input transmit_buffer_loaded_flag);
   modport dev (input wr, input data, output transmit_error_flag, output transmit_buffer_loaded_flag);
endinterface : tcp_link_if
`default_nettype wire

// ===== src/tcp_span.sv
// Word counts of one buffer from its first command word
`timescale 1ns/1ps
`default_nettype none
module tcp_span (
   input wire logic [tcp_pkg::DW-1:0] cmd_a,
   output logic [tcp_pkg::CNT_W-1:0] skip,
   output logic [tcp_pkg::CNT_W-1:0] data_cnt,
   output logic [tcp_pkg::CNT_W-1:0] total
);
   import tcp_pkg::*;
   logic [11:0] bytes;
   logic [CNT_W-1:0] used;
   logic [CNT_W-1:0] mask;
   always_comb begin
      skip = CNT_W'(cmd_a[OFF_HI:OFF_LO+2]);
      bytes = 12'(cmd_a[OFF_LO+1:OFF_LO]) + 12'(cmd_a[SIZE_HI:SIZE_LO]);
      data_cnt = CNT_W'((bytes + 12'h003) >> 2);
      used = skip + data_cnt;
      unique case (cmd_a[ALIGN_HI:ALIGN_LO])
         ALIGN_16: mask = MASK_16;
         ALIGN_32: mask = MASK_32;
         default: mask = MASK_4;
      endcase
      total = (used + mask) & ~mask;
   end
endmodule : tcp_span
`default_nettype wire

// ===== src/tcp_dev.sv
// Transmit command parser: splits command words from payload
`timescale 1ns/1ps
`default_nettype none
module tcp_dev (
   input wire logic hclk,
   input wire logic hresetn,
   tcp_link_if.dev link,
   output logic tx_valid,
   output logic [tcp_pkg::DW-1:0] tx_data,
   output logic [3:0] tx_be,
   output logic tx_first,
   output logic tx_last,
   output logic stat_valid,
   output logic [tcp_pkg::TAG_W-1:0] stat_tag
);
   import tcp_pkg::*;

   tcp_state_t state_ff;
   tcp_state_t nxt_state;
   logic [DW-1:0] cmda_ff;
   logic [DW-1:0] nxt_cmda;
   logic [DW-1:0] cmdb_ff;
   logic [DW-1:0] nxt_cmdb;
   logic in_pkt_ff;
   logic nxt_in_pkt;
   logic [CNT_W-1:0] idx_ff;
   logic [CNT_W-1:0] nxt_idx;
   logic err_ff;
   logic nxt_err;
   logic done_ff;
   logic nxt_done;
   logic tx_valid_ff;
   logic nxt_tx_valid;
   logic [DW-1:0] tx_data_ff;
   logic [DW-1:0] nxt_tx_data;
   logic [3:0] tx_be_ff;
   logic [3:0] nxt_tx_be;
   logic tx_first_ff;
   logic nxt_tx_first;
   logic tx_last_ff;
   logic nxt_tx_last;
   logic stat_valid_ff;
   logic nxt_stat_valid;
   logic [TAG_W-1:0] stat_tag_ff;
   logic [TAG_W-1:0] nxt_stat_tag;

   logic [CNT_W-1:0] skip;
   logic [CNT_W-1:0] data_cnt;
   logic [CNT_W-1:0] total;
   logic [CNT_W-1:0] last_data;
   logic [1:0] end_byte;
   logic buf_end;
   logic emit;

   tcp_span u_span (
      .cmd_a(cmda_ff),
      .skip(skip),
      .data_cnt(data_cnt),
      .total(total)
   );

   always_comb begin
      last_data = skip + data_cnt - CNT_W'(1);
      end_byte = cmda_ff[OFF_LO+1:OFF_LO] + cmda_ff[SIZE_LO+1:SIZE_LO] - 2'h1;
      emit = (idx_ff >= skip) && (idx_ff < skip + data_cnt);
      // Empty buffer ends right at the second word
      buf_end = link.wr && (((state_ff == ST_CMD_B) && (total == '0))
                || ((state_ff == ST_BODY) && (idx_ff == total - CNT_W'(1))));
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cmda = cmda_ff;
      nxt_cmdb = cmdb_ff;
      nxt_in_pkt = in_pkt_ff;
      nxt_idx = idx_ff;
      nxt_err = 1'b0;
      nxt_done = 1'b0;
      nxt_tx_valid = 1'b0;
      nxt_tx_data = tx_data_ff;
      nxt_tx_be = tx_be_ff;
      nxt_tx_first = 1'b0;
      nxt_tx_last = 1'b0;
      nxt_stat_valid = 1'b0;
      nxt_stat_tag = stat_tag_ff;
      if (link.wr) begin
         unique case (state_ff)
            ST_CMD_A: begin
               nxt_cmda = link.data;
               nxt_state = ST_CMD_B;
            end
            ST_CMD_B: begin
               nxt_idx = '0;
               nxt_state = (total == '0) ? ST_CMD_A : ST_BODY;
               if (cmda_ff[FIRST_BIT]) begin
                  nxt_in_pkt = 1'b1;
                  nxt_cmdb = link.data;
                  if (in_pkt_ff) begin
                     nxt_err = 1'b1;
                  end
               end else if (!in_pkt_ff || (link.data != cmdb_ff)) begin
                  nxt_err = 1'b1;
               end
               // Reserved alignment cannot be honoured safely
               if (cmda_ff[ALIGN_HI:ALIGN_LO] == ALIGN_RSV) begin
                  nxt_err = 1'b1;
               end
            end
            ST_BODY: begin
               nxt_idx = idx_ff + CNT_W'(1);
               // Offset words and pad words are dropped here
               if (emit) begin
                  nxt_tx_valid = 1'b1;
                  nxt_tx_data = link.data;
                  nxt_tx_be = BE_ALL;
                  if (idx_ff == skip) begin
                     nxt_tx_be = nxt_tx_be & (BE_ALL << cmda_ff[OFF_LO+1:OFF_LO]);
                     nxt_tx_first = cmda_ff[FIRST_BIT];
                  end
                  if (idx_ff == last_data) begin
                     nxt_tx_be = nxt_tx_be & (BE_ALL >> (2'h3 - end_byte));
                     nxt_tx_last = cmda_ff[LAST_BIT];
                  end
               end
               if (buf_end) begin
                  nxt_state = ST_CMD_A;
               end
            end
         endcase
      end
      if (buf_end) begin
         nxt_done = cmda_ff[IOC_BIT];
         if (cmda_ff[LAST_BIT]) begin
            nxt_in_pkt = 1'b0;
            nxt_stat_valid = 1'b1;
            nxt_stat_tag = (state_ff == ST_CMD_B && cmda_ff[FIRST_BIT]) ?
                           link.data[TAG_HI:TAG_LO] : cmdb_ff[TAG_HI:TAG_LO];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_CMD_A;
         cmda_ff <= '0;
         cmdb_ff <= '0;
         in_pkt_ff <= 1'b0;
         idx_ff <= '0;
         err_ff <= 1'b0;
         done_ff <= 1'b0;
         tx_valid_ff <= 1'b0;
         tx_data_ff <= '0;
         tx_be_ff <= '0;
         tx_first_ff <= 1'b0;
         tx_last_ff <= 1'b0;
         stat_valid_ff <= 1'b0;
         stat_tag_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cmda_ff <= nxt_cmda;
         cmdb_ff <= nxt_cmdb;
         in_pkt_ff <= nxt_in_pkt;
         idx_ff <= nxt_idx;
         err_ff <= nxt_err;
         done_ff <= nxt_done;
         tx_valid_ff <= nxt_tx_valid;
         tx_data_ff <= nxt_tx_data;
         tx_be_ff <= nxt_tx_be;
         tx_first_ff <= nxt_tx_first;
         tx_last_ff <= nxt_tx_last;
         stat_valid_ff <= nxt_stat_valid;
         stat_tag_ff <= nxt_stat_tag;
      end
   end

   assign link.transmit_error_flag = err_ff;
   assign link.transmit_buffer_loaded_flag = done_ff;
   assign tx_valid = tx_valid_ff;
   assign tx_data = tx_data_ff;
   assign tx_be = tx_be_ff;
   assign tx_first = tx_first_ff;
   assign tx_last = tx_last_ff;
   assign stat_valid = stat_valid_ff;
   assign stat_tag = stat_tag_ff;
endmodule : tcp_dev
`default_nettype wire

// ===== src/tcp_host.sv
// Host controller: AHB-Lite registers feeding the command link
`timescale 1ns/1ps
`default_nettype none
module tcp_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   tcp_link_if.host link
);
   import tcp_pkg::*;

   logic wsel_ff;
   logic nxt_wsel;
   logic [7:0] waddr_ff;
   logic [7:0] nxt_waddr;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;
   logic wr_ff;
   logic nxt_wr;
   logic [DW-1:0] data_ff;
   logic [DW-1:0] nxt_data;
   logic [IRQ_W-1:0] stat_ff;
   logic [IRQ_W-1:0] nxt_stat;
   logic [IRQ_W-1:0] mask_ff;
   logic [IRQ_W-1:0] nxt_mask;
   logic take;
   logic [IRQ_W-1:0] evt;

   always_comb begin
      take = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
      evt = '0;
      evt[STAT_ERR_BIT] = link.transmit_error_flag;
      evt[STAT_DONE_BIT] = link.transmit_buffer_loaded_flag;
      nxt_wsel = take && hwrite;
      nxt_waddr = take ? haddr[7:0] : waddr_ff;
      nxt_hrdata = '0;
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            REG_STAT: nxt_hrdata = 32'(stat_ff);
            REG_MASK: nxt_hrdata = 32'(mask_ff);
            default: nxt_hrdata = '0;
         endcase
      end
      nxt_wr = 1'b0;
      nxt_data = data_ff;
      nxt_mask = mask_ff;
      nxt_stat = stat_ff;
      if (wsel_ff) begin
         unique case (waddr_ff)
            // Command words and payload share one port, in host order
            REG_DATA: begin
               nxt_wr = 1'b1;
               nxt_data = hwdata;
            end
            REG_STAT: nxt_stat = stat_ff & ~hwdata[IRQ_W-1:0];
            REG_MASK: nxt_mask = hwdata[IRQ_W-1:0];
            default: nxt_wr = 1'b0;
         endcase
      end
      // Set wins over a same-cycle clear
      nxt_stat = nxt_stat | evt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wsel_ff <= 1'b0;
         waddr_ff <= '0;
         hrdata_ff <= '0;
         wr_ff <= 1'b0;
         data_ff <= '0;
         stat_ff <= '0;
         mask_ff <= '0;
      end else begin
         wsel_ff <= nxt_wsel;
         waddr_ff <= nxt_waddr;
         hrdata_ff <= nxt_hrdata;
         wr_ff <= nxt_wr;
         data_ff <= nxt_data;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_ff;
   assign irq = |(stat_ff & mask_ff);
   assign link.wr = wr_ff;
   assign link.data = data_ff;
endmodule : tcp_host
`default_nettype wire

// ===== tb/tcp_link_monitor.sv
// Assertions on the command link between host controller and parser
`timescale 1ns/1ps
`default_nettype none
module tcp_link_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic wr,
   input wire logic [tcp_pkg::DW-1:0] data,
   input wire logic transmit_error_flag,
   input wire logic transmit_buffer_loaded_flag
);
   import tcp_pkg::*;
   tcp_state_t st_ff, nxt_st;
   logic [DW-1:0] a_ff, nxt_a, b_ff, nxt_b, bref_ff, nxt_bref, cur_b;
   logic [CNT_W-1:0] rem_ff, nxt_rem, span, msk, tot;
   logic open_ff, nxt_open, end_ev, err_seq, err_tag, err_al, cmd_b_ev;
   // Buffer ends recovered from the word stream alone
   always_comb begin
      span = CNT_W'((12'(a_ff[OFF_LO+1:OFF_LO]) + 12'(a_ff[SIZE_HI:SIZE_LO]) + 12'h003) >> 2)
         + CNT_W'(a_ff[OFF_HI:OFF_LO+2]);
      msk = (a_ff[ALIGN_HI:ALIGN_LO] == ALIGN_16) ? MASK_16 : (a_ff[ALIGN_HI:ALIGN_LO] == ALIGN_32) ? MASK_32 : MASK_4;
      tot = (span + msk) & ~msk;
      cur_b = (st_ff == ST_CMD_B) ? data : b_ff;
      err_al = a_ff[ALIGN_HI:ALIGN_LO] == ALIGN_RSV;
      err_seq = a_ff[FIRST_BIT] ? open_ff : !open_ff;
      err_tag = !a_ff[FIRST_BIT] && open_ff && (cur_b != bref_ff);
      nxt_st = st_ff;
      nxt_a = a_ff;
      nxt_b = b_ff;
      nxt_rem = rem_ff;
      nxt_open = open_ff;
      nxt_bref = bref_ff;
      end_ev = 1'b0;
      // Parser judges a buffer on its second word, before any body
      cmd_b_ev = wr && (st_ff == ST_CMD_B);
      if (wr) begin
         case (st_ff)
            ST_CMD_A: begin
               nxt_a = data;
               nxt_st = ST_CMD_B;
            end
            ST_CMD_B: begin
               nxt_b = data;
               nxt_rem = tot;
               end_ev = tot == '0;
               nxt_st = end_ev ? ST_CMD_A : ST_BODY;
            end
            default: begin
               nxt_rem = rem_ff - 10'h001;
               end_ev = rem_ff == 10'h001;
               nxt_st = end_ev ? ST_CMD_A : ST_BODY;
            end
         endcase
      end
      // Reference word kept only from an opening buffer
      if (end_ev) begin
         nxt_open = !a_ff[LAST_BIT] && (a_ff[FIRST_BIT] || open_ff);
         nxt_bref = a_ff[FIRST_BIT] ? cur_b : bref_ff;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= ST_CMD_A;
         a_ff <= '0;
         b_ff <= '0;
         bref_ff <= '0;
         rem_ff <= '0;
         open_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         a_ff <= nxt_a;
         b_ff <= nxt_b;
         bref_ff <= nxt_bref;
         rem_ff <= nxt_rem;
         open_ff <= nxt_open;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_buf_end;
      end_ev;
   endsequence
   sequence s_loaded_end;
      s_buf_end ##0 a_ff[IOC_BIT];
   endsequence
   sequence s_cmd_b;
      cmd_b_ev;
   endsequence
   chk_loaded_after_end: assert property (s_loaded_end |=> transmit_buffer_loaded_flag)
      else $error("loaded flag missing after buffer");
   chk_loaded_unasked: assert property (s_buf_end ##0 !a_ff[IOC_BIT] |=> !transmit_buffer_loaded_flag)
      else $error("loaded flag without request");
   chk_loaded_cause: assert property (transmit_buffer_loaded_flag |-> $past(end_ev))
      else $error("loaded flag away from buffer end");
   chk_error_cause: assert property (transmit_error_flag |-> $past(cmd_b_ev))
      else $error("error flag away from second command word");
   chk_tag_mismatch: assert property (s_cmd_b ##0 err_tag |=> transmit_error_flag)
      else $error("second word mismatch not flagged");
   chk_align_reserved: assert property (s_cmd_b ##0 err_al |=> transmit_error_flag)
      else $error("reserved alignment not flagged");
   chk_segment_order: assert property (s_cmd_b ##0 err_seq |=> transmit_error_flag)
      else $error("segment order fault not flagged");
   chk_clean_buffer: assert property (s_cmd_b ##0 !(err_al || err_seq || err_tag) |=> !transmit_error_flag)
      else $error("error flag on a clean buffer");
endmodule : tcp_link_monitor
`default_nettype wire

// ===== tb/testbench.sv
// Testbench joining host controller and parser over the command link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tcp_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, tx_valid, tx_first, tx_last, stat_valid;
   logic [31:0] haddr, hwdata, hrdata, rd, tx_data;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] tx_be;
   logic [TAG_W-1:0] stat_tag;
   logic [37:0] txq[$];
   int n_mismatch, n_checks, n_stat;
   tcp_link_if link ();
   tcp_host tcp_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .irq(irq), .link(link.host));
   tcp_dev tcp_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(link.dev), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_be(tx_be), .tx_first(tx_first), .tx_last(tx_last), .stat_valid(stat_valid), .stat_tag(stat_tag));
   tcp_link_monitor tcp_link_monitor_inst (.hclk(hclk), .hresetn(hresetn), .wr(link.wr), .data(link.data),
      .transmit_error_flag(link.transmit_error_flag), .transmit_buffer_loaded_flag(link.transmit_buffer_loaded_flag));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (tx_valid) txq.push_back({tx_first, tx_last, tx_be, tx_data});
      if (stat_valid) n_stat++;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic check(input logic [37:0] seen, input logic [37:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %0h against %0h", $time, seen, exp);
      end
   endtask : check
   // Read data taken at the same edge that samples ready high
   task automatic wait_rdy();
      for (int i = 0; i < 20; i++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) begin
            rd = hrdata;
            return;
         end
      end
      n_mismatch++;
      stop_test();
   endtask : wait_rdy
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h00000000);
      check(38'(rd), 38'(exp));
      check(38'(hresp), 38'(HRESP_OKAY));
   endtask : rchk
   // Fixed wait covers the link latency of the hand-over walk
   task automatic send(input logic [31:0] a, input logic [31:0] b, input int n);
      bus(REG_DATA, 1'b1, a);
      bus(REG_DATA, 1'b1, b);
      for (int i = 0; i < n; i++) bus(REG_DATA, 1'b1, 32'hA0000000 + 32'(i));
      repeat (4) @(posedge hclk);
   endtask : send
   task automatic txchk(input logic [37:0] exp);
      check((txq.size() != 0) ? txq.pop_front() : 38'hX, exp);
   endtask : txchk
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      n_mismatch = 0;
      n_checks = 0;
      n_stat = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(REG_STAT, 32'h00000000);
      send(32'h80003008, 32'h12340000, 2);
      txchk({2'h2, BE_ALL, 32'hA0000000});
      txchk({2'h1, BE_ALL, 32'hA0000001});
      check(38'(stat_tag), 38'h1234);
      rchk(REG_STAT, 32'h00000002);
      check(38'(irq), 38'h0);
      bus(REG_MASK, 1'b1, 32'h00000003);
      rchk(8'h40, 32'h00000000);
      check(38'(irq), 38'h1);
      bus(REG_STAT, 1'b1, 32'h00000002);
      rchk(REG_STAT, 32'h00000000);
      check(38'(irq), 38'h0);
      $display("single buffer test done");
      send(32'h01053006, 32'h00770000, 4);
      txchk({2'h2, 4'hE, 32'hA0000001});
      txchk({2'h1, 4'h7, 32'hA0000002});
      check(38'(txq.size()), 38'h0);
      rchk(REG_STAT, 32'h00000000);
      $display("offset and pad test done");
      send(32'h02002004, 32'h00550000, 8);
      send(32'h80001004, 32'h00550000, 1);
      txchk({2'h2, BE_ALL, 32'hA0000000});
      txchk({2'h1, BE_ALL, 32'hA0000000});
      check(38'(stat_tag), 38'h0055);
      rchk(REG_STAT, 32'h00000002);
      bus(REG_STAT, 1'b1, 32'h00000002);
      $display("multi buffer test done");
      send(32'h00002004, 32'h00010000, 1);
      send(32'h00001004, 32'h00020000, 1);
      rchk(REG_STAT, 32'h00000001);
      check(38'(irq), 38'h1);
      bus(REG_STAT, 1'b1, 32'h00000001);
      send(32'h03003004, 32'h00000000, 1);
      rchk(REG_STAT, 32'h00000001);
      bus(REG_STAT, 1'b1, 32'h00000001);
      send(32'h00001004, 32'h00000000, 1);
      rchk(REG_STAT, 32'h00000001);
      check(38'(txq.size()), 38'h4);
      check(38'(n_stat), 38'h6);
      $display("error test done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
